// file: hdl/sfcf_consts.vh
// constants for the serial flash command front end
// Overview of operation
// [R1] erased array reads all ones; programming only clears bits
// [R2] sectors hold 16 subsectors of 4 KB on 4 KB aligned addresses
// [R3] subsector n spans n*0x1000 to n*0x1000+0xfff, linear byte map
// [R4] capacity set by density: 8x16 up to 256x16 subsectors
// [R5] opcodes, addresses and data move msb first both ways
// [R6] opcode enters on serial input lane at serial clock rising edges
// [R7] host sends address/data then raises select after final bit
// [R8] device drives read data; host may stop after any output bit
// [R9] write/erase not on byte boundary at select release is discarded
// [R10] memory access during busy write/erase cycle is rejected
// [R11] status bit 7 is reserved read/write, resets to zero
// [R12] host issues write enable 06h before any write or erase
// [R13] status readable anytime; busy bit one while cycle runs
// [R14] read 03h takes 3-byte address, streams bytes, wraps at top
// [R15] select high clears bit counter and awaits new opcode
// [R16] clock edges counted per frame to check byte boundary
`ifndef SFCF_CONSTS_VH
`define SFCF_CONSTS_VH
`define SFCF_OP_WREN 8'h06
`define SFCF_OP_WRDI 8'h04
`define SFCF_OP_RDSR 8'h05
`define SFCF_OP_WRSR 8'h01
`define SFCF_OP_READ 8'h03
`define SFCF_OP_PROG 8'h02
`define SFCF_OP_SE 8'hd8
`define SFCF_OP_SSE 8'h20
`define SFCF_OP_BE 8'hc7
`define SFCF_ST_WIP 0
`define SFCF_ST_WEL 1
`define SFCF_ST_RSV7 7
`define SFCF_ST_RESET 8'h00
`define SFCF_ERASED 8'hff
`define SFCF_SUB_BITS 12
`define SFCF_SUB_PER_SEC 16
`define SFCF_ER_SUB 5'd12
`define SFCF_ER_SEC 5'd16
`define SFCF_ER_ALL 5'd24
`define SFCF_BUSY_NS 10000
`define SFCF_CLK_MHZ 50
`define SFCF_BUSY_CYC ((`SFCF_BUSY_NS * `SFCF_CLK_MHZ) / 1000)
`endif

// file: hdl/sfcf_sync.v
// two-flop synchroniser for the pin inputs
`timescale 1ns/1ps
module sfcf_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q_ff
);
  reg [W-1:0] meta_ff;
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_ff <= INIT;
      q_ff <= INIT;
    end
    else
    begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
endmodule // sfcf_sync

// file: hdl/sfcf_top.v
// serial flash command front end with small array model
`timescale 1ns/1ps
`include "sfcf_consts.vh"
module sfcf_top #(
  parameter SECTORS = 8,
  parameter MEM_BYTES = 4096,
  parameter BUSY_CYC = `SFCF_BUSY_CYC
) (
  input wire clk,
  input wire rst_n,
  input wire select_active_low,
  input wire serial_clock_in,
  input wire serial_in_lane,
  input wire hw_reset_low,
  output reg serial_out_lane_ff,
  output reg serial_out_oe_n_ff,
  output reg busy_ff,
  output reg [7:0] flash_status_ff
);
  // ==========================================
  // address space
  localparam MBITS = $clog2(MEM_BYTES);
  // [R2] [R3] [R4] linear map: addr[23:12] is the subsector index
  localparam integer TOP_INT = ((SECTORS * `SFCF_SUB_PER_SEC) << `SFCF_SUB_BITS) - 1;
  localparam [23:0] TOP_ADDR = TOP_INT[23:0];

  // ==========================================
  // pin synchronisers
  wire [3:0] pins_s;
  // idle levels: select high, clock low, lane low, reset pin high
  sfcf_sync #(.W(4), .INIT(4'b1001)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({select_active_low, serial_clock_in, serial_in_lane, hw_reset_low}),
    .q_ff(pins_s)
  );
  wire sel_n = pins_s[3];
  wire sck = pins_s[2];
  wire sdi = pins_s[1];
  wire hrst_n = pins_s[0];
  reg sck_d_ff;
  always @(posedge clk)
  begin
    if (!rst_n)
      sck_d_ff <= 1'b0;
    else
      sck_d_ff <= sck;
  end
  wire rise = !sel_n && sck && !sck_d_ff;
  wire fall = !sel_n && !sck && sck_d_ff;

  // ==========================================
  // frame state
  localparam [1:0] S_OP = 2'd0, S_ADDR = 2'd1, S_DATA = 2'd2, S_IGN = 2'd3;
  reg [1:0] state_ff;
  reg [7:0] op_ff;
  reg [7:0] sh_ff;
  reg [2:0] bit_ff;
  reg [1:0] abyte_ff;
  reg [23:0] addr_ff;
  reg [7:0] out_ff;
  reg [15:0] edges_ff;
  reg sel_d_ff;
  reg [7:0] wbuf_ff;
  reg wbuf_v_ff;
  reg [31:0] busy_cnt_ff;
  reg [7:0] mem [0:MEM_BYTES-1];
  reg [7:0] rd_byte;
  integer ei;
  wire [7:0] nxt_sh = {sh_ff[6:0], sdi}; // [R5]
  wire [23:0] addr_in = {addr_ff[15:0], nxt_sh} & TOP_ADDR;
  // erase grain as a shift: subsector, sector or the whole array
  wire [4:0] er_lo = (op_ff == `SFCF_OP_SSE) ? `SFCF_ER_SUB :
                     (op_ff == `SFCF_OP_SE) ? `SFCF_ER_SEC : `SFCF_ER_ALL; // [R2]
  // program and status write need a whole data byte before they may start
  wire data_ok = wbuf_v_ff || !((op_ff == `SFCF_OP_PROG) || (op_ff == `SFCF_OP_WRSR));
  wire byte_done = rise && (bit_ff == 3'd7);
  wire [23:0] nxt_addr = (addr_ff == TOP_ADDR) ? 24'h000000 : addr_ff + 24'h000001; // [R14]
  wire is_wr = (op_ff == `SFCF_OP_PROG) || (op_ff == `SFCF_OP_SE) ||
               (op_ff == `SFCF_OP_SSE) || (op_ff == `SFCF_OP_BE) ||
               (op_ff == `SFCF_OP_WRSR);
  wire rst_all = !rst_n || !hrst_n;

  always @*
  begin
    rd_byte = mem[addr_ff[MBITS-1:0]];
  end

  integer i;
  initial
  begin
    for (i = 0; i < MEM_BYTES; i = i + 1)
      mem[i] = `SFCF_ERASED; // [R1]
  end

  always @(posedge clk)
  begin
    if (!rst_n)
      sel_d_ff <= 1'b1;
    else
      sel_d_ff <= sel_n;
  end

  always @(posedge clk)
  begin
    if (rst_all)
    begin
      state_ff <= S_OP;
      op_ff <= 8'h00;
      sh_ff <= 8'h00;
      bit_ff <= 3'd0;
      abyte_ff <= 2'd0;
      addr_ff <= 24'h000000;
      out_ff <= 8'h00;
      edges_ff <= 16'h0000;
      wbuf_ff <= 8'h00;
      wbuf_v_ff <= 1'b0;
      busy_ff <= 1'b0;
      busy_cnt_ff <= 32'h00000000;
      flash_status_ff <= `SFCF_ST_RESET; // [R11]
      serial_out_lane_ff <= 1'b0;
      serial_out_oe_n_ff <= 1'b1;
    end
    else
    begin
      if (busy_ff)
      begin
        busy_cnt_ff <= busy_cnt_ff - 32'h00000001;
        if (busy_cnt_ff == 32'h00000001)
        begin
          busy_ff <= 1'b0;
          flash_status_ff[`SFCF_ST_WIP] <= 1'b0; // [R13]
          flash_status_ff[`SFCF_ST_WEL] <= 1'b0;
        end
      end
      if (sel_n)
      begin
        // [R15] select high: reset framing, ignore the clock
        state_ff <= S_OP;
        bit_ff <= 3'd0;
        abyte_ff <= 2'd0;
        edges_ff <= 16'h0000;
        wbuf_v_ff <= 1'b0;
        serial_out_oe_n_ff <= 1'b1;
        // only a frame that reached its data phase (past the address, or past the opcode for BE and WRSR)
        // counts, so a stale opcode from an earlier frame never fires again
        if (!sel_d_ff && is_wr && state_ff == S_DATA && data_ok && !busy_ff &&
            flash_status_ff[`SFCF_ST_WEL] && edges_ff[2:0] == 3'd0) // [R9] [R16] [R12]
        begin
          busy_ff <= 1'b1;
          busy_cnt_ff <= BUSY_CYC;
          flash_status_ff[`SFCF_ST_WIP] <= 1'b1;
          if (op_ff == `SFCF_OP_WRSR && wbuf_v_ff)
            flash_status_ff[7:2] <= wbuf_ff[7:2]; // [R11] bit 7 writable
          else if (op_ff == `SFCF_OP_PROG && wbuf_v_ff)
            mem[addr_ff[MBITS-1:0]] <= rd_byte & wbuf_ff; // [R1]
          else if (op_ff != `SFCF_OP_WRSR && op_ff != `SFCF_OP_PROG)
          begin
            // erase limited to the modelled window; one byte per clock
            // would be long, so the whole span is cleared here at once
            for (ei = 0; ei < MEM_BYTES; ei = ei + 1)
              if ((ei[MBITS-1:0] >> er_lo) == (addr_ff[MBITS-1:0] >> er_lo))
                mem[ei[MBITS-1:0]] <= `SFCF_ERASED; // [R1] [R2]
          end
        end
      end
      else
      begin
        if (rise)
        begin
          edges_ff <= edges_ff + 16'h0001; // [R16]
          sh_ff <= nxt_sh;
          bit_ff <= bit_ff + 3'd1;
        end
        if (byte_done)
        begin
          case (state_ff)
            S_OP:
            begin
              op_ff <= nxt_sh; // [R6]
              if (nxt_sh == `SFCF_OP_RDSR)
              begin
                state_ff <= S_DATA; // [R13]
                out_ff <= flash_status_ff;
              end
              else if (busy_ff)
                state_ff <= S_IGN; // [R10]
              else if (nxt_sh == `SFCF_OP_WREN)
              begin
                flash_status_ff[`SFCF_ST_WEL] <= 1'b1;
                state_ff <= S_IGN;
              end
              else if (nxt_sh == `SFCF_OP_WRDI)
              begin
                flash_status_ff[`SFCF_ST_WEL] <= 1'b0;
                state_ff <= S_IGN;
              end
              else if (nxt_sh == `SFCF_OP_WRSR)
                state_ff <= S_DATA;
              else if (nxt_sh == `SFCF_OP_BE)
                state_ff <= S_DATA;
              else
                state_ff <= S_ADDR;
            end
            S_ADDR:
            begin
              addr_ff <= addr_in; // [R14]
              abyte_ff <= abyte_ff + 2'd1;
              if (abyte_ff == 2'd2)
              begin
                state_ff <= S_DATA;
                out_ff <= mem[addr_in[MBITS-1:0]];
              end
            end
            S_DATA:
            begin
              if (op_ff == `SFCF_OP_READ)
              begin
                addr_ff <= nxt_addr; // [R14]
                out_ff <= mem[nxt_addr[MBITS-1:0]];
              end
              else if (op_ff == `SFCF_OP_RDSR)
                out_ff <= flash_status_ff; // [R13]
              else
              begin
                wbuf_ff <= nxt_sh;
                wbuf_v_ff <= 1'b1;
              end
            end
            default: state_ff <= S_IGN;
          endcase
        end
        // [R8] [R5] data leaves msb first on falling edges
        if (fall && state_ff == S_DATA &&
            (op_ff == `SFCF_OP_READ || op_ff == `SFCF_OP_RDSR))
        begin
          serial_out_oe_n_ff <= 1'b0;
          serial_out_lane_ff <= out_ff[3'd7 - bit_ff];
        end
      end
    end
  end
endmodule // sfcf_top

// file: verification/sfcf_host.sv
// host model that frames operations on the serial pins
`timescale 1ns/1ps
module sfcf_host (
  input wire clk,
  input wire sout,
  input wire oe_n,
  output reg sel_n = 1'b1,
  output reg sclk = 1'b0,
  output reg sin = 1'b0,
  output reg [7:0] rx = 8'h00,
  output reg rx_stb = 1'b0
);
  reg rd;
  task open_f;
  begin
    @(negedge clk);
    sel_n = 1'b0;
    repeat (3) @(negedge clk);
  end
  endtask
  task close_f;
  begin
    @(negedge clk);
    sel_n = 1'b1;
    // clock idles low between frames, dropped together with select
    sclk = 1'b0;
    // released lane flips so a stale level is never mistaken for data
    sin = ~sin;
    repeat (6) @(negedge clk);
  end
  endtask
  // 160 ns bit: 5 clocks low, 3 high, read lane sampled late in the high phase
  task bit_x(input b);
  begin
    @(negedge clk);
    sclk = 1'b0;
    sin = b;
    repeat (5) @(negedge clk);
    sclk = 1'b1;
    repeat (2) @(negedge clk);
    // an undriven lane reads inverted so early release shows as bad data
    rx = {rx[6:0], oe_n ? ~sout : sout};
    rd = !oe_n;
  end
  endtask
  task byte_x(input [7:0] b);
    integer i;
  begin
    for (i = 7; i >= 0; i = i - 1)
      bit_x(b[i]);
    rx_stb = rd;
    @(negedge clk);
    rx_stb = 1'b0;
  end
  endtask
endmodule // sfcf_host

// file: verification/sfcf_top_properties.sv
// port checker for sfcf_top
`timescale 1ns/1ps
module sfcf_props #(
  parameter BUSY_CYC = 20
) (
  input wire clk,
  input wire rst_n,
  input wire select_active_low,
  input wire serial_clock_in,
  input wire serial_in_lane,
  input wire hw_reset_low,
  input wire serial_out_lane_ff,
  input wire serial_out_oe_n_ff,
  input wire busy_ff,
  input wire [7:0] flash_status_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  reg [15:0] cnt_ff;
  always @(posedge clk)
    cnt_ff <= busy_ff ? cnt_ff + 16'h1 : 16'h0;
  reset_vals_a: assert property ($rose(rst_n) |-> flash_status_ff == 8'h00
    && serial_out_oe_n_ff && !busy_ff) else $error("bad reset");
  busy_bit_a: assert property (busy_ff == flash_status_ff[0]) else $error("wip");
  busy_wel_a: assert property (busy_ff |-> flash_status_ff[1]) else $error("wel");
  busy_len_a: assert property ($fell(busy_ff) |-> cnt_ff >= BUSY_CYC - 1
    && cnt_ff <= BUSY_CYC + 1) else $error("busy len");
  busy_start_a: assert property ($rose(busy_ff) |-> select_active_low) else $error("start");
  idle_oe_a: assert property (select_active_low [*5] |-> serial_out_oe_n_ff)
    else $error("oe idle");
  drive_sel_a: assert property ($fell(serial_out_oe_n_ff) |-> !select_active_low)
    else $error("oe frame");
  lane_edge_a: assert property ($changed(serial_out_lane_ff) |-> !serial_clock_in)
    else $error("lane edge");
  pin_reset_a: assert property ((!hw_reset_low) [*4] |-> flash_status_ff == 8'h00
    && !busy_ff && serial_out_oe_n_ff) else $error("pin reset");
  cover property ((!hw_reset_low) [*4]);
  cover property ($rose(busy_ff));
  cover property ($fell(busy_ff));
  cover property ($fell(serial_out_oe_n_ff));
endmodule // sfcf_props
bind sfcf_top sfcf_props #(.BUSY_CYC(BUSY_CYC)) props_i (.clk(clk), .rst_n(rst_n),
  .select_active_low(select_active_low), .serial_clock_in(serial_clock_in),
  .serial_in_lane(serial_in_lane), .hw_reset_low(hw_reset_low),
  .serial_out_lane_ff(serial_out_lane_ff), .serial_out_oe_n_ff(serial_out_oe_n_ff),
  .busy_ff(busy_ff), .flash_status_ff(flash_status_ff));

// file: verification/tb.sv
// self-checking bench for sfcf_top
`timescale 1ns/1ps
module tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg hrst_n = 1'b1;
  wire sel_n, sclk, sin, sout, oe_n, busy, rx_stb;
  wire [7:0] st, rx;
  reg [7:0] exp_q[$];
  integer error_cnt = 0;
  integer n_tests = 0;
  reg [31:0] rs = 32'hd77deb2d;
  reg [23:0] a;
  reg [7:0] d;
  reg [7:0] e;
  initial
  begin
    forever #10 clk = ~clk;
  end
  sfcf_host h (.clk(clk), .sout(sout), .oe_n(oe_n), .sel_n(sel_n), .sclk(sclk),
    .sin(sin), .rx(rx), .rx_stb(rx_stb));
  // busy long enough to fit a status read and a refused read inside it
  sfcf_top #(.BUSY_CYC(600)) dut (.clk(clk), .rst_n(rst_n), .select_active_low(sel_n),
    .serial_clock_in(sclk), .serial_in_lane(sin), .hw_reset_low(hrst_n),
    .serial_out_lane_ff(sout), .serial_out_oe_n_ff(oe_n), .busy_ff(busy),
    .flash_status_ff(st));
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
  begin
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    xs = y ^ (y << 5);
  end
  endfunction
  task chk(input [7:0] s, input [7:0] x);
  begin
    n_tests = n_tests + 1;
    if (s !== x)
    begin
      error_cnt = error_cnt + 1;
      $display("Error at %0t: saw %h want %h", $time, s, x);
    end
  end
  endtask
  task final_report;
  begin
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  always @(posedge clk)
    if (rx_stb === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(rx, ~rx);
      else
        chk(rx, exp_q.pop_front());
    end
  task wait_busy(input v);
    integer i;
  begin
    for (i = 0; busy !== v && i < 2000; i = i + 1)
      @(negedge clk);
    if (busy !== v)
      chk(busy, v);
    if (busy !== v)
      final_report;
  end
  endtask
  task op(input [7:0] c, input [23:0] ad, input n, input integer k, input [7:0] dt);
    integer i;
  begin
    h.open_f;
    h.byte_x(c);
    if (n)
    begin
      h.byte_x(ad[23:16]);
      h.byte_x(ad[15:8]);
      h.byte_x(ad[7:0]);
    end
    for (i = 0; i < k; i = i + 1)
      h.byte_x(dt);
    h.close_f;
  end
  endtask
  task wr(input [23:0] ad, input [7:0] dt, input x);
  begin
    op(8'h06, 0, 0, 0, 0);
    h.open_f;
    op_body(ad, dt);
    if (x)
      h.bit_x(1'b0);
    h.close_f;
  end
  endtask
  task op_body(input [23:0] ad, input [7:0] dt);
  begin
    h.byte_x(8'h02);
    h.byte_x(ad[23:16]);
    h.byte_x(ad[15:8]);
    h.byte_x(ad[7:0]);
    h.byte_x(dt);
  end
  endtask
  initial
  begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk(st, 8'h00);
    rs = xs(rs);
    a = {12'h000, rs[11:1], 1'b0};
    d = rs[23:16];
    e = rs[31:24];
    exp_q = '{8'hff, 8'hff};
    op(8'h03, 24'h07ffff, 1, 2, 0);
    wr(a, d, 0);
    wait_busy(1);
    exp_q.push_back(8'h03);
    op(8'h05, 0, 0, 1, 0);
    op(8'h03, a, 1, 1, 0);
    wait_busy(0);
    chk(st, 8'h00);
    wr(a ^ 24'h1, 8'h00, 1);
    repeat (40) @(negedge clk);
    chk(busy, 1'b0);
    wr(a, e, 0);
    wait_busy(1);
    wait_busy(0);
    exp_q.push_back(d & e);
    exp_q.push_back(8'hff);
    op(8'h03, a, 1, 2, 0);
    // subsector erase, then a write after write disable must be refused
    op(8'h06, 0, 0, 0, 0);
    op(8'h20, a, 1, 0, 0);
    wait_busy(1);
    wait_busy(0);
    op(8'h06, 0, 0, 0, 0);
    op(8'h04, 0, 0, 0, 0);
    op(8'h02, a, 1, 1, 8'h00);
    repeat (40) @(negedge clk);
    chk(busy, 1'b0);
    exp_q.push_back(8'hff);
    exp_q.push_back(8'hff);
    op(8'h03, a, 1, 2, 0);
    // status write, then the reset pin clears it again
    op(8'h06, 0, 0, 0, 0);
    op(8'h01, 0, 0, 1, e);
    wait_busy(1);
    wait_busy(0);
    chk(st, {e[7:2], 2'b00});
    exp_q.push_back({e[7:2], 2'b00});
    op(8'h05, 0, 0, 1, 0);
    hrst_n = 1'b0;
    repeat (4) @(negedge clk);
    hrst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(st, 8'h00);
    chk({7'h00, exp_q.size() != 0}, 8'h00);
    final_report;
  end
endmodule // tb
